// ==== hdl/rbs_params.svh ====
// Constants for the broadcast message sequencer: offsets, fields, resets, timing
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RBS_OFF_CTRL 8'h00
`define RBS_OFF_RTADDR 8'h04
`define RBS_OFF_DATA 8'h08
`define RBS_OFF_ERROR 8'h0c
`define RBS_OFF_STATE 8'h10
`define RBS_OFF_IRQ_STAT 8'h14
`define RBS_OFF_IRQ_MASK 8'h18

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RBS_CTRL_EN_BIT 0
`define RBS_IRQ_DONE_BIT 0
`define RBS_IRQ_BAD_BIT 1
`define RBS_ERR_WORD_BIT 0
`define RBS_ERR_ILLEGAL_BIT 1
`define RBS_CTRL_RST 1'b0
`define RBS_RTADDR_RST 5'h00
`define RBS_MASK_RST 2'h0
`define RBS_CMD_ADDR_HI 15
`define RBS_CMD_ADDR_LO 11
`define RBS_CMD_TR_BIT 10
`define RBS_CMD_SA_HI 9
`define RBS_CMD_SA_LO 5
`define RBS_CMD_WC_HI 4
`define RBS_CMD_WC_LO 0
`define RBS_BCAST_ADDR 5'h1f
`define RBS_STAT_MERR_BIT 10
`define RBS_STAT_BCAST_BIT 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define RBS_CLK_NS 8
`define RBS_PULSE_NS 500

`endif

// ==== hdl/rbs_pkg.sv ====
// Types shared by the broadcast message sequencer files
`default_nettype none
package rbs_pkg;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [9:0] {
        S_IDLE  = 10'h001,
        S_CMD   = 10'h002,
        S_WAIT  = 10'h004,
        S_DATA  = 10'h008,
        S_TXOUT = 10'h010,
        S_STAT  = 10'h020,
        S_LAST  = 10'h040,
        S_ERR   = 10'h080,
        S_RXREG = 10'h100,
        S_FIN   = 10'h200
    } rbs_state_t;

    // ----------------------------------------
    // Kind of word in a memory write cycle
    // ----------------------------------------
    typedef enum logic [2:0] {
        K_CMD = 3'h0,
        K_DATA = 3'h1,
        K_STATUS = 3'h2,
        K_LASTCMD = 3'h3,
        K_ERROR = 3'h4,
        K_RXREG = 3'h5
    } rbs_kind_t;

endpackage
`default_nettype wire

// ==== hdl/rbs_mem_cycle.sv ====
// One memory write cycle: request, wait for grant, then put the word out
`timescale 1ns/1ns
`default_nettype none
module rbs_mem_cycle (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Sequencer side
    input wire logic start,
    input wire logic [15:0] word,
    input wire rbs_pkg::rbs_kind_t kind,
    input wire logic grant,
    output logic busy,
    output logic done,
    // Memory side
    output logic xferReq,
    output logic [15:0] memData,
    output logic memWrite,
    output rbs_pkg::rbs_kind_t memKind
);
    logic busy_q;
    logic write_q;
    logic armed_q;
    logic [15:0] word_q;
    logic [15:0] data_q;
    rbs_pkg::rbs_kind_t kind_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_q <= 1'b0;
            write_q <= 1'b0;
            armed_q <= 1'b0;
            word_q <= 16'h0000;
            data_q <= 16'h0000;
            kind_q <= rbs_pkg::K_CMD;
        end else begin
            write_q <= 1'b0;
            // Grant must be seen low after start before it counts, so a grant still held from the last cycle is not taken;
            // a host that never releases grant between cycles stalls the sequencer
            if (!busy_q && start) begin
                busy_q <= 1'b1;
                armed_q <= 1'b0;
                word_q <= word;
                kind_q <= kind;
            end else if (busy_q && !grant) begin
                armed_q <= 1'b1;
            end else if (busy_q && grant && armed_q) begin
                // Word leaves only once the host has let go of the bus
                busy_q <= 1'b0;
                write_q <= 1'b1;
                data_q <= word_q;
            end
        end
    end

    assign busy = busy_q;
    assign done = write_q;
    assign xferReq = busy_q;
    assign memData = data_q;
    assign memWrite = write_q;
    assign memKind = kind_q;

    grant_before_write_a: assert property (@(posedge core_clk) disable iff (reset)
        memWrite |-> $past(grant) && $past(busy_q) && $past(armed_q))
        else $error("memory write without a preceding grant");
endmodule
`default_nettype wire

// ==== hdl/rbs_pulse_low.sv ====
// Active-low output pulse of fixed width, restarted by each trigger
`timescale 1ns/1ns
`default_nettype none
module rbs_pulse_low #(
    parameter int WIDTH = 62
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Trigger and pulse
    input wire logic trig,
    output logic pulseN
);
    localparam int CW = $clog2(WIDTH + 1);
    localparam logic [CW-1:0] LOAD = CW'(WIDTH);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt_q;
    logic pulseN_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q <= '0;
            pulseN_q <= 1'b1;
        end else begin
            // Low for WIDTH cycles after the last trigger; a trigger held high keeps it low
            pulseN_q <= !(trig || cnt_q > ONE);
            if (trig) begin
                cnt_q <= LOAD;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - ONE;
            end
        end
    end

    assign pulseN = pulseN_q;

    pulse_ends_a: assert property (@(posedge core_clk) disable iff (reset)
        !pulseN && cnt_q == '0 |=> pulseN)
        else $error("low pulse held beyond its width");
endmodule
`default_nettype wire

// ==== hdl/rbs_sequencer.sv ====
// Broadcast-aware message sequencer of the serial terminal, with APB registers
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rbs_params.svh"

// What this block does
// - Broadcast: status not sent, still written
// - Broadcast receive: cmd, data, status, last, error
// - Mode code, count MSB high: one data word
// - Mode code, count MSB low: no data
// - Receiver waits any gap before first data
// - Broadcast receivers store status, never send it
// - Transmitter after broadcast receive skips receive register
// - Done pulse after error register, broadcast error-free
// - Done pulse after final register written
// - Controller: done after status or last data
// - Done on address load, data read, error read
// - Done and bad outputs are low pulses
// - Bad pulse on broadcast with transmit bit
// - Bad pulse on error during broadcast
// - Broadcast data error sets message error bit
// - Request first, word out only after grant
module rbs_sequencer #(
    parameter int PULSE_NS = `RBS_PULSE_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Word decoder
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic dataValid,
    input wire logic [15:0] dataWord,
    input wire logic wordError,
    input wire logic txDataDone,
    output logic statusSend,
    // Controller datapath events
    input wire logic bcStatusStored,
    input wire logic bcLastDataStored,
    input wire logic bcCmdIsReceive,
    // Pins
    input wire logic roleSelect,
    input wire logic busGrantAckN,
    output logic xferReq,
    output logic [15:0] memData,
    output logic memWrite,
    output rbs_pkg::rbs_kind_t memKind,
    output logic modeCodeFlag,
    output logic messageDonePulseN,
    output logic badMessagePulseN
);
    localparam int PulseCycles = (PULSE_NS / `RBS_CLK_NS) < 1 ? 1 : PULSE_NS / `RBS_CLK_NS;

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic isModeCode(input logic [15:0] c);
        logic [4:0] sa;
        sa = c[`RBS_CMD_SA_HI:`RBS_CMD_SA_LO];
        return sa == 5'h00 || sa == 5'h1f;
    endfunction

    function automatic logic [5:0] wordsNeeded(input logic [15:0] c);
        logic [4:0] wc;
        wc = c[`RBS_CMD_WC_HI:`RBS_CMD_WC_LO];
        if (isModeCode(c)) begin
            return wc[4] ? 6'h01 : 6'h00;
        end
        return (wc == 5'h00) ? 6'h20 : {1'b0, wc};
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        return a == `RBS_OFF_CTRL || a == `RBS_OFF_RTADDR || a == `RBS_OFF_DATA || a == `RBS_OFF_ERROR
            || a == `RBS_OFF_STATE || a == `RBS_OFF_IRQ_STAT || a == `RBS_OFF_IRQ_MASK;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] roleSync_q;
    logic [1:0] grantSync_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            roleSync_q <= 2'h0;
            grantSync_q <= 2'h3;
        end else begin
            roleSync_q <= {roleSync_q[0], roleSelect};
            grantSync_q <= {grantSync_q[0], busGrantAckN};
        end
    end

    wire logic rtRole = roleSync_q[1];
    wire logic grantOn = !grantSync_q[1];

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic enable_q;
    logic [4:0] rtAddr_q;
    logic [1:0] irqMask_q;
    logic [1:0] irqStat_q;
    logic [1:0] errReg_q;
    logic [31:0] prdata_q;
    rbs_pkg::rbs_state_t state_q;
    logic [15:0] rxWord_q;

    wire logic apbAccess = psel && penable;
    wire logic apbWrite = apbAccess && pwrite && isMapped(paddr);
    wire logic apbRead = apbAccess && !pwrite && isMapped(paddr);
    wire logic irqClear = apbRead && paddr == `RBS_OFF_IRQ_STAT;
    wire logic errClear = apbRead && paddr == `RBS_OFF_ERROR;

    assign pready = 1'b1;
    assign pslverr = apbAccess && !isMapped(paddr);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_q <= `RBS_CTRL_RST;
            rtAddr_q <= `RBS_RTADDR_RST;
            irqMask_q <= `RBS_MASK_RST;
        end else if (apbWrite) begin
            case (paddr)
                `RBS_OFF_CTRL: begin
                    enable_q <= pwdata[`RBS_CTRL_EN_BIT];
                end
                `RBS_OFF_RTADDR: begin
                    rtAddr_q <= pwdata[4:0];
                end
                `RBS_OFF_IRQ_MASK: begin
                    irqMask_q <= pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is fetched in the setup phase so the access phase needs no wait
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `RBS_OFF_CTRL: prdata_q <= {31'h0000_0000, enable_q};
                `RBS_OFF_RTADDR: prdata_q <= {27'h000_0000, rtAddr_q};
                `RBS_OFF_DATA: prdata_q <= {16'h0000, rxWord_q};
                `RBS_OFF_ERROR: prdata_q <= {30'h0000_0000, errReg_q};
                `RBS_OFF_STATE: prdata_q <= {20'h0_0000, rtRole, xferReq, state_q};
                `RBS_OFF_IRQ_STAT: prdata_q <= {30'h0000_0000, irqStat_q};
                `RBS_OFF_IRQ_MASK: prdata_q <= {30'h0000_0000, irqMask_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire logic [4:0] cmdAddr = cmdWord[`RBS_CMD_ADDR_HI:`RBS_CMD_ADDR_LO];
    wire logic cmdTr = cmdWord[`RBS_CMD_TR_BIT];
    wire logic cmdBcast = cmdAddr == `RBS_BCAST_ADDR;
    wire logic cmdSeen = cmdValid && enable_q && rtRole && state_q == rbs_pkg::S_IDLE;
    wire logic illegalBcast = cmdSeen && cmdBcast && cmdTr;
    wire logic cmdTake = cmdSeen && (cmdAddr == rtAddr_q || cmdBcast) && !illegalBcast;

    // ----------------------------------------
    // Message sequencer
    // ----------------------------------------
    logic [15:0] cmd_q;
    logic isBcast_q;
    logic isTx_q;
    logic skipRx_q;
    logic prevBcastRx_q;
    logic [5:0] wordsLeft_q;
    logic errFlag_q;
    logic memBusy;
    logic memDone;
    logic memStart;
    logic [15:0] memWord;
    rbs_pkg::rbs_kind_t memWordKind;
    logic statusSend_q;
    logic modeCode_q;

    wire logic busyMsg = state_q != rbs_pkg::S_IDLE;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= rbs_pkg::S_IDLE;
            cmd_q <= 16'h0000;
            isBcast_q <= 1'b0;
            isTx_q <= 1'b0;
            skipRx_q <= 1'b0;
            prevBcastRx_q <= 1'b0;
            wordsLeft_q <= 6'h00;
            errFlag_q <= 1'b0;
            rxWord_q <= 16'h0000;
        end else begin
            if (wordError && busyMsg) begin
                errFlag_q <= 1'b1;
            end
            case (state_q)
                rbs_pkg::S_IDLE: begin
                    if (cmdTake) begin
                        cmd_q <= cmdWord;
                        isBcast_q <= cmdBcast;
                        isTx_q <= cmdTr;
                        // A transmit right after a broadcast receive is the far end of a broadcast transfer
                        skipRx_q <= prevBcastRx_q;
                        prevBcastRx_q <= cmdBcast && !cmdTr;
                        wordsLeft_q <= wordsNeeded(cmdWord);
                        errFlag_q <= 1'b0;
                        state_q <= rbs_pkg::S_CMD;
                    end
                end
                rbs_pkg::S_CMD: begin
                    if (memDone) begin
                        state_q <= (isTx_q || wordsLeft_q == 6'h00) ? rbs_pkg::S_STAT : rbs_pkg::S_WAIT;
                    end
                end
                rbs_pkg::S_WAIT: begin
                    // No limit on the gap before the first data word
                    if (wordError) begin
                        state_q <= rbs_pkg::S_STAT;
                    end else if (dataValid) begin
                        rxWord_q <= dataWord;
                        state_q <= rbs_pkg::S_DATA;
                    end
                end
                rbs_pkg::S_DATA: begin
                    if (memDone) begin
                        wordsLeft_q <= wordsLeft_q - 6'h01;
                        state_q <= (wordsLeft_q == 6'h01) ? rbs_pkg::S_STAT : rbs_pkg::S_WAIT;
                    end
                end
                rbs_pkg::S_STAT: begin
                    if (memDone) begin
                        state_q <= (isTx_q && wordsLeft_q != 6'h00) ? rbs_pkg::S_TXOUT : rbs_pkg::S_LAST;
                    end
                end
                rbs_pkg::S_TXOUT: begin
                    if (txDataDone) begin
                        state_q <= rbs_pkg::S_LAST;
                    end
                end
                rbs_pkg::S_LAST: begin
                    if (memDone) begin
                        state_q <= rbs_pkg::S_ERR;
                    end
                end
                rbs_pkg::S_ERR: begin
                    if (memDone) begin
                        // Broadcasts never store the receive register
                        state_q <= (isBcast_q || (isTx_q && skipRx_q)) ? rbs_pkg::S_FIN : rbs_pkg::S_RXREG;
                    end
                end
                rbs_pkg::S_RXREG: begin
                    if (memDone) begin
                        state_q <= rbs_pkg::S_FIN;
                    end
                end
                rbs_pkg::S_FIN: begin
                    state_q <= rbs_pkg::S_IDLE;
                end
                default: begin
                    state_q <= rbs_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Memory word selection
    // ----------------------------------------
    wire logic [15:0] statusWord = {rtAddr_q, errFlag_q, 5'h00, isBcast_q, 4'h0};

    always_comb begin
        memWord = cmd_q;
        memWordKind = rbs_pkg::K_CMD;
        case (state_q)
            rbs_pkg::S_DATA: begin
                memWord = rxWord_q;
                memWordKind = rbs_pkg::K_DATA;
            end
            rbs_pkg::S_STAT: begin
                memWord = statusWord;
                memWordKind = rbs_pkg::K_STATUS;
            end
            rbs_pkg::S_LAST: begin
                memWord = cmd_q;
                memWordKind = rbs_pkg::K_LASTCMD;
            end
            rbs_pkg::S_ERR: begin
                memWord = {14'h0000, errReg_q};
                memWordKind = rbs_pkg::K_ERROR;
            end
            rbs_pkg::S_RXREG: begin
                memWord = rxWord_q;
                memWordKind = rbs_pkg::K_RXREG;
            end
            default: begin
            end
        endcase
    end

    wire logic writeState = state_q == rbs_pkg::S_CMD || state_q == rbs_pkg::S_DATA || state_q == rbs_pkg::S_STAT
        || state_q == rbs_pkg::S_LAST || state_q == rbs_pkg::S_ERR || state_q == rbs_pkg::S_RXREG;
    // Gate on done too, or the state that just finished would start a second cycle
    assign memStart = writeState && !memBusy && !memDone;

    rbs_mem_cycle u_mem (
        .core_clk(core_clk),
        .reset(reset),
        .start(memStart),
        .word(memWord),
        .kind(memWordKind),
        .grant(grantOn),
        .busy(memBusy),
        .done(memDone),
        .xferReq(xferReq),
        .memData(memData),
        .memWrite(memWrite),
        .memKind(memKind)
    );

    // ----------------------------------------
    // Serial status request and mode code flag
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            statusSend_q <= 1'b0;
            modeCode_q <= 1'b0;
        end else begin
            statusSend_q <= memStart && state_q == rbs_pkg::S_STAT && !isBcast_q;
            if (cmdTake) begin
                modeCode_q <= isModeCode(cmdWord);
            end
        end
    end

    assign statusSend = statusSend_q;
    assign modeCodeFlag = modeCode_q;

    // ----------------------------------------
    // Events, error register and interrupt
    // ----------------------------------------
    wire logic rtDone = state_q == rbs_pkg::S_FIN && (!isBcast_q || !errFlag_q);
    wire logic bcDone = !rtRole && ((bcStatusStored && bcCmdIsReceive) || (bcLastDataStored && !bcCmdIsReceive));
    wire logic hostDone = (apbWrite && paddr == `RBS_OFF_RTADDR)
        || (apbRead && (paddr == `RBS_OFF_DATA || paddr == `RBS_OFF_ERROR));
    wire logic bcastErr = wordError && busyMsg && isBcast_q;
    wire logic doneTrig = rtDone || bcDone || hostDone;
    wire logic badTrig = illegalBcast || bcastErr;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            errReg_q <= 2'h0;
            irqStat_q <= 2'h0;
        end else begin
            // A new event wins over a clear in the same cycle
            errReg_q <= (errClear ? 2'h0 : errReg_q) | {illegalBcast, wordError && busyMsg};
            irqStat_q <= (irqClear ? 2'h0 : irqStat_q) | {badTrig, doneTrig};
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    rbs_pulse_low #(.WIDTH(PulseCycles)) u_done_pulse (
        .core_clk(core_clk),
        .reset(reset),
        .trig(doneTrig),
        .pulseN(messageDonePulseN)
    );

    rbs_pulse_low #(.WIDTH(PulseCycles)) u_bad_pulse (
        .core_clk(core_clk),
        .reset(reset),
        .trig(badTrig),
        .pulseN(badMessagePulseN)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence statDone_s;
        state_q == rbs_pkg::S_STAT && memDone;
    endsequence

    status_not_sent_a: assert property (statusSend |-> !isBcast_q && $past(state_q == rbs_pkg::S_STAT))
        else $error("status sent for a broadcast");
    bcast_rx_order_a: assert property (statDone_s ##0 (isBcast_q && !isTx_q) |=> state_q == rbs_pkg::S_LAST)
        else $error("broadcast status not followed by last command");
    mode_one_word_a: assert property (cmdTake && cmdBcast && isModeCode(cmdWord) && cmdWord[4]
        |=> wordsLeft_q == 6'h01)
        else $error("broadcast mode code with data not one word");
    mode_no_word_a: assert property (cmdTake && isModeCode(cmdWord) && !cmdWord[4]
        |=> state_q == rbs_pkg::S_CMD ##0 wordsLeft_q == 6'h00)
        else $error("mode code without data expects words");
    no_rxreg_bcast_a: assert property (state_q == rbs_pkg::S_RXREG |-> !isBcast_q && !(isTx_q && skipRx_q))
        else $error("receive register stored for broadcast");
    gap_wait_a: assert property (state_q == rbs_pkg::S_WAIT && !dataValid && !wordError
        |=> state_q == rbs_pkg::S_WAIT)
        else $error("left the data wait with no word");
    done_after_fin_a: assert property (state_q == rbs_pkg::S_FIN && isBcast_q && !errFlag_q
        |-> ##[1:2] !messageDonePulseN)
        else $error("no done pulse after broadcast");
    bad_on_tr_a: assert property (illegalBcast |-> ##[1:2] !badMessagePulseN ##1 state_q == rbs_pkg::S_IDLE)
        else $error("no bad pulse on broadcast transmit");
    no_done_err_a: assert property (state_q == rbs_pkg::S_FIN && isBcast_q && errFlag_q && !bcDone && !hostDone
        |-> !doneTrig)
        else $error("done pulse after faulty broadcast");
endmodule
`default_nettype wire

// ==== sim/rbs_grant_model.sv ====
// Memory-side partner: grants the bus a set time after each request
`timescale 1ns/1ns
`default_nettype none
module rbs_grant_model #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Handshake
    input wire logic xferReq,
    output logic busGrantAckN
);
    int cnt;
    // Grant only while asked, so a late grant never leaks into the next cycle
    always_ff @(posedge core_clk) begin
        cnt <= (reset || !xferReq) ? 0 : cnt + 1;
        busGrantAckN <= !(xferReq && !reset && cnt >= DELAY);
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the broadcast message sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seq;
    logic pready, pslverr, irq, cmdValid = 0, dataValid = 0, wordError = 0, txDataDone = 0, sent;
    logic [15:0] cmdWord = 16'h0, dataWord = 16'h0, memData, lastStat;
    logic statusSend, xferReq, memWrite, modeCodeFlag, messageDonePulseN, badMessagePulseN, busGrantAckN;
    rbs_pkg::rbs_kind_t memKind;
    int error_cnt = 0, checks_done = 0;
    logic role = 1, bcStat = 0, bcLast = 0, bcRx = 0;
    always #4 core_clk = ~core_clk;
    // Short pulses keep the run brief: 40 ns is 5 cycles
    rbs_sequencer #(.PULSE_NS(40)) dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .cmdValid, .cmdWord, .dataValid, .dataWord, .wordError,
        .txDataDone, .statusSend, .bcStatusStored(bcStat), .bcLastDataStored(bcLast), .bcCmdIsReceive(bcRx),
        .roleSelect(role), .busGrantAckN, .xferReq, .memData, .memWrite, .memKind, .modeCodeFlag,
        .messageDonePulseN, .badMessagePulseN);
    rbs_grant_model gm (.core_clk, .reset, .xferReq, .busGrantAckN);
    // Write log: one octal digit per memory write, behind a leading 1
    always @(posedge core_clk) begin
        if (memWrite) seq <= {seq[28:0], memKind};
        if (memWrite && memKind === rbs_pkg::K_STATUS) lastStat <= memData;
        if (statusSend) sent <= 1'b1;
    end
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Data words arrive late on purpose; err sends a word error instead
    task automatic msg(logic [15:0] c, int n, logic err, logic tx, logic [31:0] exp, logic [1:0] pul);
        int i;
        @(posedge core_clk);
        seq = 32'h1;
        sent = 0;
        cmdValid <= 1; cmdWord <= c;
        @(posedge core_clk); cmdValid <= 0;
        for (i = 0; i < n; i++) begin
            repeat (30) @(posedge core_clk);
            dataValid <= !err; wordError <= err; dataWord <= 16'h5a00 + 16'(i);
            @(posedge core_clk); dataValid <= 0; wordError <= 0;
        end
        if (tx) begin
            repeat (40) @(posedge core_clk);
            txDataDone <= 1;
            @(posedge core_clk); txDataDone <= 0;
        end
        for (i = 0; i < 300 && messageDonePulseN === 1'b1 && badMessagePulseN === 1'b1; i++) @(posedge core_clk);
        #1 chk("pulses", {messageDonePulseN, badMessagePulseN}, pul);
        repeat (40) @(posedge core_clk);
        chk("write order", seq, exp);
        chk("status sent", sent, tx);
        chk("req idle", xferReq, 0);
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 0;
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h04, 32'h5);
        repeat (3) @(posedge core_clk);
        #1 chk("load done", messageDonePulseN, 0);
        chk("irq masked", irq, 0);
        apb(1, 8'h18, 32'h3);
        #1 chk("irq on", irq, 1);
        apb(0, 8'h14, 32'h0);
        #1 chk("irq clear", {rd[0], irq}, 2'b10);
        apb(0, 8'h1c, 32'h0);
        chk("unmapped err", perr, 1);
        chk("unmapped data", rd, 0);
        repeat (10) @(posedge core_clk);
        // Broadcast receive, then transmit to one terminal
        msg(16'hf822, 2, 0, 0, 32'o1011234, 2'b01);
        chk("merr clear", lastStat[10], 0);
        msg(16'h2c21, 0, 0, 1, 32'o10234, 2'b01);
        msg(16'hf810, 1, 0, 0, 32'o101234, 2'b01);
        chk("mode flag", modeCodeFlag, 1);
        msg(16'hf800, 0, 0, 0, 32'o10234, 2'b01);
        msg(16'hfc22, 0, 0, 0, 32'o1, 2'b10);
        msg(16'hf822, 1, 1, 0, 32'o10234, 2'b10);
        chk("merr set", lastStat[10], 1);
        apb(0, 8'h08, 32'h0);
        #1 chk("data read", rd, 32'h5a00);
        chk("data done", messageDonePulseN, 0);
        repeat (10) @(posedge core_clk);
        apb(0, 8'h0c, 32'h0);
        #1 chk("error read", {rd[1:0], messageDonePulseN}, 3'b110);
        // Controller role: done follows the stored-word events
        repeat (10) @(posedge core_clk);
        role <= 0; bcRx <= 1;
        repeat (3) @(posedge core_clk);
        bcStat <= 1;
        @(posedge core_clk); bcStat <= 0;
        #1 chk("bc rx done", messageDonePulseN, 0);
        repeat (10) @(posedge core_clk);
        bcRx <= 0; bcStat <= 1;
        @(posedge core_clk); bcStat <= 0; bcLast <= 1;
        #1 chk("bc tx status", messageDonePulseN, 1);
        @(posedge core_clk); bcLast <= 0;
        #1 chk("bc tx done", messageDonePulseN, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
